/* include/rpq_regs.vh */
// register map, field positions, reset values and timing counts of the qualifier
`ifndef RPQ_REGS_VH
`define RPQ_REGS_VH
// ********************************************************************
// register indices, byte address is four times the index
// ********************************************************************
`define RPQ_IDX_STATUS1 8'h03
`define RPQ_IDX_STATUS2 8'h04
`define RPQ_IDX_TXCTRL 8'h08
`define RPQ_IDX_HDRCTL1 8'h32
`define RPQ_IDX_HDRCTL2 8'h33
`define RPQ_IDX_PRELEN 8'h34
`define RPQ_IDX_PRECTL 8'h35
`define RPQ_IDX_SYNC 8'h36
`define RPQ_IDX_PKTLEN 8'h3e
`define RPQ_IDX_CHKHDR 8'h3f
`define RPQ_IDX_HDREN 8'h43
`define RPQ_IDX_RXHDR 8'h47
`define RPQ_IDX_INVPRE 8'h60
// ********************************************************************
// reset values
// ********************************************************************
`define RPQ_RST_HDRCTL1 8'h00
`define RPQ_RST_HDRCTL2 8'h22
`define RPQ_RST_PRELEN 8'h08
`define RPQ_RST_PRECTL 8'h2a
`define RPQ_RST_SYNC 32'h2dd40000
`define RPQ_RST_PKTLEN 8'h00
`define RPQ_RST_CHKHDR 32'h00000000
`define RPQ_RST_HDREN 32'hffffffff
`define RPQ_RST_INVPRE 8'h00
`define RPQ_RST_TXCTRL 16'h3000
// ********************************************************************
// field positions
// ********************************************************************
`define RPQ_TXC_TXON 0
`define RPQ_TXC_AUTO 1
`define RPQ_TXC_GPSEL 2
`define RPQ_ST1_SENT 0
`define RPQ_ST1_AEMPTY 1
`define RPQ_ST1_HDRERR 2
`define RPQ_ST2_PREDET 0
`define RPQ_ST2_INVPRE 1
`define RPQ_ST2_SYNC 2
// ********************************************************************
// timing counts in bit periods
// ********************************************************************
`define RPQ_SYNC_EXTRA_BITS 6'd4
`define RPQ_BITS_PER_UNIT 4
`endif

/* hdl/rpq_top.v */
// receive preamble, sync and header qualifier with retransmit and auto transmit
`timescale 1ns/1ps
`include "rpq_regs.vh"
module rpq_top (
  // clock, reset and freeze
  input wire CORE_CLK_I,
  input wire RSTN_I,
  input wire CLK_EN_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [9:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // demodulated bit stream
  input wire RX_ENABLE_I,
  input wire RX_BIT_I,
  input wire RX_BIT_VALID_I,
  // transmit fifo status
  input wire [6:0] TX_FIFO_LEVEL_I,
  input wire TX_FIFO_WRITE_I,
  input wire TX_PKT_FITS_I,
  input wire TX_PKT_SENT_I,
  input wire TX_ALMOST_EMPTY_I,
  // receive results
  output reg PREAMBLE_DET_O,
  output reg INVALID_PREAMBLE_O,
  output reg GPIO_O,
  output reg SYNC_FOUND_O,
  output reg HEADER_OK_O,
  output reg HEADER_FAIL_O,
  output reg [31:0] RX_HEADER_O,
  // transmit control
  output reg TX_START_O,
  output reg TX_RETX_O,
  output reg TX_ACTIVE_O,
  output reg [7:0] TX_PKT_LEN_O,
  output reg [8:0] TX_PREAMBLE_LEN_O,
  output reg [31:0] TX_SYNC_WORD_O,
  output reg [1:0] TX_SYNC_LEN_O
);

  // ********************************************************************
  // receive states, one-hot
  // ********************************************************************
  localparam [2:0] ST_PRE = 3'b001;
  localparam [2:0] ST_SYNC = 3'b010;
  localparam [2:0] ST_HDR = 3'b100;

  // ********************************************************************
  // configuration and status registers
  // ********************************************************************
  reg [7:0] hdr_ctl1;
  reg [7:0] hdr_ctl2;
  reg [7:0] pre_len;
  reg [7:0] pre_ctl;
  reg [31:0] sync_word;
  reg [7:0] pkt_len;
  reg [31:0] chk_hdr;
  reg [31:0] hdr_en;
  reg [7:0] inv_ctl;
  reg [15:0] tx_ctl;
  reg [2:0] status1;
  reg [2:0] status2;

  // field views
  wire [3:0] bcast_en = hdr_ctl1[7:4];
  wire [3:0] hdr_check = hdr_ctl1[3:0];
  wire [2:0] hdr_len = hdr_ctl2[6:4];
  wire [1:0] sync_len = hdr_ctl2[2:1];
  wire [4:0] pre_thresh = pre_ctl[7:3];
  wire [3:0] invalid_preamble_window = inv_ctl[7:4];
  wire auto_tx = tx_ctl[`RPQ_TXC_AUTO];
  wire [5:0] afull_thr = tx_ctl[13:8];

  // ********************************************************************
  // apb decode
  // ********************************************************************
  wire [7:0] idx = PADDR_I[9:2];
  wire setup_ph = PSEL_I & ~PENABLE_I;
  wire acc_done = PSEL_I & PENABLE_I & PREADY_O;
  wire wr_en = acc_done & PWRITE_I & ~PSLVERR_O;
  wire rd_en = acc_done & ~PWRITE_I & ~PSLVERR_O;
  reg [31:0] rd_mux;
  reg hit;

  // read mux, narrow registers in the low bits, upper bits zero
  always @* begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (idx)
      `RPQ_IDX_STATUS1: rd_mux = {29'h0, status1};
      `RPQ_IDX_STATUS2: rd_mux = {29'h0, status2};
      `RPQ_IDX_TXCTRL: rd_mux = {16'h0, tx_ctl};
      `RPQ_IDX_HDRCTL1: rd_mux = {24'h0, hdr_ctl1};
      `RPQ_IDX_HDRCTL2: rd_mux = {24'h0, hdr_ctl2};
      `RPQ_IDX_PRELEN: rd_mux = {24'h0, pre_len};
      `RPQ_IDX_PRECTL: rd_mux = {24'h0, pre_ctl};
      `RPQ_IDX_SYNC: rd_mux = sync_word;
      `RPQ_IDX_PKTLEN: rd_mux = {24'h0, pkt_len};
      `RPQ_IDX_CHKHDR: rd_mux = chk_hdr;
      `RPQ_IDX_HDREN: rd_mux = hdr_en;
      `RPQ_IDX_RXHDR: rd_mux = RX_HEADER_O;
      `RPQ_IDX_INVPRE: rd_mux = {24'h0, inv_ctl};
      default: hit = 1'b0;
    endcase
    if (PADDR_I[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  // no wait state: data and error are settled in the setup cycle so that
  // every bus output leaves a flip-flop
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else if (CLK_EN_I) begin
      PREADY_O <= setup_ph;
      if (setup_ph) begin
        PRDATA_O <= hit ? rd_mux : 32'h00000000;
        PSLVERR_O <= ~hit;
      end else if (acc_done) begin
        PSLVERR_O <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // configuration writes
  // ********************************************************************
  wire txon_wr = wr_en & (idx == `RPQ_IDX_TXCTRL) &
                 PWDATA_I[`RPQ_TXC_TXON];

  // transmit-on does not stick, it only launches a start request
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      hdr_ctl1 <= `RPQ_RST_HDRCTL1;
      hdr_ctl2 <= `RPQ_RST_HDRCTL2;
      pre_len <= `RPQ_RST_PRELEN;
      pre_ctl <= `RPQ_RST_PRECTL;
      sync_word <= `RPQ_RST_SYNC;
      pkt_len <= `RPQ_RST_PKTLEN;
      chk_hdr <= `RPQ_RST_CHKHDR;
      hdr_en <= `RPQ_RST_HDREN;
      inv_ctl <= `RPQ_RST_INVPRE;
      tx_ctl <= `RPQ_RST_TXCTRL;
    end else if (CLK_EN_I && wr_en) begin
      case (idx)
        `RPQ_IDX_HDRCTL1: hdr_ctl1 <= PWDATA_I[7:0];
        `RPQ_IDX_HDRCTL2: hdr_ctl2 <= PWDATA_I[7:0];
        `RPQ_IDX_PRELEN: pre_len <= PWDATA_I[7:0];
        `RPQ_IDX_PRECTL: pre_ctl <= PWDATA_I[7:0];
        `RPQ_IDX_SYNC: sync_word <= PWDATA_I;
        `RPQ_IDX_PKTLEN: pkt_len <= PWDATA_I[7:0];
        `RPQ_IDX_CHKHDR: chk_hdr <= PWDATA_I;
        `RPQ_IDX_HDREN: hdr_en <= PWDATA_I;
        `RPQ_IDX_INVPRE: inv_ctl <= PWDATA_I[7:0];
        `RPQ_IDX_TXCTRL: tx_ctl <= {2'b00, PWDATA_I[13:8], 5'h00,
                                    PWDATA_I[2:1], 1'b0};
        default: tx_ctl <= tx_ctl;
      endcase
    end
  end

  // ********************************************************************
  // receive bit tracking
  // ********************************************************************
  reg [2:0] state;
  reg [2:0] next_state;
  reg prev_bit;
  reg have_prev;
  reg [7:0] run_cnt;
  reg [7:0] win_cnt;
  reg [31:0] shift;
  reg tmo_run;
  reg [5:0] tmo_cnt;
  reg [5:0] hdr_cnt;
  reg inv_flag;

  wire bit_in = RX_BIT_VALID_I & RX_ENABLE_I;
  wire [31:0] next_shift = {shift[30:0], RX_BIT_I};
  // alternation keeps the run going, a repeated bit restarts it
  wire alt = have_prev & (RX_BIT_I != prev_bit);
  wire [7:0] next_run = alt ? run_cnt + 8'd1 : 8'd1;
  wire [7:0] pre_need = {1'b0, pre_thresh, 2'b00};
  wire pre_hit = (state == ST_PRE) & bit_in & (pre_thresh != 5'd0) &
                 (next_run >= pre_need);
  wire [7:0] win_need = {2'b00, invalid_preamble_window, 2'b00};
  wire [7:0] next_win = win_cnt + 8'd1;
  wire inv_hit = (state == ST_PRE) & bit_in & ~inv_flag & ~pre_hit &
                 (invalid_preamble_window != 4'd0) &
                 (next_win == win_need);

  // ********************************************************************
  // sync comparison, sync byte 3 arrives first
  // ********************************************************************
  reg [31:0] sync_exp;
  reg [31:0] sync_mask;
  reg [5:0] sync_bits;
  always @* begin
    case (sync_len)
      2'b00: begin
        sync_exp = {24'h0, sync_word[31:24]};
        sync_mask = 32'h000000ff;
        sync_bits = 6'd8;
      end
      2'b01: begin
        sync_exp = {16'h0, sync_word[31:16]};
        sync_mask = 32'h0000ffff;
        sync_bits = 6'd16;
      end
      2'b10: begin
        sync_exp = {8'h0, sync_word[31:8]};
        sync_mask = 32'h00ffffff;
        sync_bits = 6'd24;
      end
      default: begin
        sync_exp = sync_word;
        sync_mask = 32'hffffffff;
        sync_bits = 6'd32;
      end
    endcase
  end

  wire sync_hit = (state == ST_SYNC) & bit_in &
                  (((next_shift ^ sync_exp) & sync_mask) == 32'h0);
  // the clock starts only once the pattern stops looking like preamble
  wire tmo_start = tmo_run | ~alt;
  wire [5:0] tmo_lim = sync_bits + `RPQ_SYNC_EXTRA_BITS;
  wire [5:0] next_tmo = tmo_cnt + 6'd1;
  wire tmo_hit = (state == ST_SYNC) & bit_in & ~sync_hit & tmo_start &
                 (next_tmo >= tmo_lim);

  // ********************************************************************
  // header capture and check
  // ********************************************************************
  wire hdr_used = (hdr_len >= 3'd1) & (hdr_len <= 3'd4);
  wire [5:0] hdr_need = {hdr_len, 3'b000};
  wire [5:0] next_hcnt = hdr_cnt + 6'd1;
  wire hdr_done = (state == ST_HDR) & bit_in & (next_hcnt == hdr_need);
  reg [31:0] rx_hdr;

  // first received header byte lands in byte 3
  always @* begin
    case (hdr_len)
      3'd1: rx_hdr = {next_shift[7:0], 24'h0};
      3'd2: rx_hdr = {next_shift[15:0], 16'h0};
      3'd3: rx_hdr = {next_shift[23:0], 8'h0};
      default: rx_hdr = next_shift;
    endcase
  end

  wire [3:0] byte_pass;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_hdr
      wire [7:0] rb = rx_hdr[8*gi+7:8*gi];
      wire [7:0] eb = chk_hdr[8*gi+7:8*gi];
      wire [7:0] mb = hdr_en[8*gi+7:8*gi];
      wire masked_ok = (((rb ^ eb) & mb) == 8'h00);
      wire bcast_ok = bcast_en[gi] & (rb == 8'hff);
      // unselected bytes always pass, whatever the header length
      assign byte_pass[gi] = ~hdr_check[gi] | masked_ok |
                             bcast_ok;
    end
  endgenerate
  wire hdr_all_ok = &byte_pass;

  // ********************************************************************
  // receive state machine
  // ********************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_PRE: begin
        if (pre_hit) begin
          next_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (sync_hit) begin
          next_state = hdr_used ? ST_HDR : ST_PRE;
        end else if (tmo_hit) begin
          next_state = ST_PRE;
        end
      end
      ST_HDR: begin
        if (hdr_done) begin
          next_state = ST_PRE;
        end
      end
      default: next_state = ST_PRE;
    endcase
    if (!RX_ENABLE_I) begin
      next_state = ST_PRE;
    end
  end

  // counters except run_cnt restart on every state change, all restart when receive is off
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      state <= ST_PRE;
      prev_bit <= 1'b0;
      have_prev <= 1'b0;
      run_cnt <= 8'd0;
      win_cnt <= 8'd0;
      shift <= 32'h0;
      tmo_run <= 1'b0;
      tmo_cnt <= 6'd0;
      hdr_cnt <= 6'd0;
      inv_flag <= 1'b0;
    end else if (CLK_EN_I) begin
      state <= next_state;
      if (!RX_ENABLE_I) begin
        have_prev <= 1'b0;
        run_cnt <= 8'd0;
        win_cnt <= 8'd0;
        tmo_run <= 1'b0;
        tmo_cnt <= 6'd0;
        hdr_cnt <= 6'd0;
        inv_flag <= 1'b0;
      end else if (bit_in) begin
        prev_bit <= RX_BIT_I;
        have_prev <= 1'b1;
        shift <= next_shift;
        run_cnt <= (next_run == 8'hff) ? run_cnt : next_run;
        if (next_state != state) begin
          win_cnt <= 8'd0;
          tmo_run <= 1'b0;
          tmo_cnt <= 6'd0;
          hdr_cnt <= 6'd0;
          inv_flag <= 1'b0;
        end else begin
          if (state == ST_PRE && !inv_flag) begin
            win_cnt <= next_win;
          end
          if (inv_hit) begin
            inv_flag <= 1'b1;
          end
          if (state == ST_SYNC && tmo_start) begin
            tmo_run <= 1'b1;
            tmo_cnt <= next_tmo;
          end
          if (state == ST_HDR) begin
            hdr_cnt <= next_hcnt;
          end
        end
      end
    end
  end

  // ********************************************************************
  // transmit launch: fifo reload tracking, retransmit and auto start
  // ********************************************************************
  reg reloaded;
  // a resend needs an unchanged fifo holding the whole packet
  wire retx_ok = ~reloaded & TX_PKT_FITS_I;
  wire man_go = txon_wr & ~TX_ACTIVE_O & (reloaded | retx_ok);
  wire auto_go = auto_tx & ~TX_ACTIVE_O & ~man_go &
                 (TX_FIFO_LEVEL_I > {1'b0, afull_thr});
  wire st1_clear = rd_en & (idx == `RPQ_IDX_STATUS1);
  wire tx_stop = st1_clear &
                 (status1[`RPQ_ST1_SENT] | status1[`RPQ_ST1_AEMPTY]);

  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      reloaded <= 1'b0;
      TX_START_O <= 1'b0;
      TX_RETX_O <= 1'b0;
      TX_ACTIVE_O <= 1'b0;
    end else if (CLK_EN_I) begin
      TX_START_O <= man_go | auto_go;
      if (man_go | auto_go) begin
        TX_RETX_O <= man_go & ~reloaded;
        TX_ACTIVE_O <= 1'b1;
        reloaded <= TX_FIFO_WRITE_I;
      end else begin
        if (TX_FIFO_WRITE_I) begin
          reloaded <= 1'b1;
        end
        // the link stays keyed until software reads off the flags
        if (tx_stop) begin
          TX_ACTIVE_O <= 1'b0;
          TX_RETX_O <= 1'b0;
        end
      end
    end
  end

  // ********************************************************************
  // sticky status, cleared by a read, a new event wins over the clear
  // ********************************************************************
  wire [2:0] ev1 = {hdr_done & ~hdr_all_ok, TX_ALMOST_EMPTY_I & TX_ACTIVE_O,
                    TX_PKT_SENT_I & TX_ACTIVE_O};
  wire [2:0] ev2 = {sync_hit, inv_hit, pre_hit};
  wire st2_clear = rd_en & (idx == `RPQ_IDX_STATUS2);

  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      status1 <= 3'b000;
      status2 <= 3'b000;
    end else if (CLK_EN_I) begin
      status1 <= (st1_clear ? 3'b000 : status1) | ev1;
      status2 <= (st2_clear ? 3'b000 : status2) | ev2;
    end
  end

  // ********************************************************************
  // receive result outputs
  // ********************************************************************
  wire pre_level = (next_state != ST_PRE);
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      PREAMBLE_DET_O <= 1'b0;
      INVALID_PREAMBLE_O <= 1'b0;
      GPIO_O <= 1'b0;
      SYNC_FOUND_O <= 1'b0;
      HEADER_OK_O <= 1'b0;
      HEADER_FAIL_O <= 1'b0;
      RX_HEADER_O <= 32'h0;
    end else if (CLK_EN_I) begin
      PREAMBLE_DET_O <= pre_level;
      INVALID_PREAMBLE_O <= RX_ENABLE_I & (inv_flag | inv_hit) &
                            (next_state == ST_PRE);
      // the pin shows either qualifier, chosen by software
      GPIO_O <= tx_ctl[`RPQ_TXC_GPSEL] ?
                (RX_ENABLE_I & (inv_flag | inv_hit) &
                 (next_state == ST_PRE)) : pre_level;
      SYNC_FOUND_O <= sync_hit;
      HEADER_OK_O <= hdr_done & hdr_all_ok;
      HEADER_FAIL_O <= hdr_done & ~hdr_all_ok;
      if (hdr_done) begin
        RX_HEADER_O <= rx_hdr;
      end
    end
  end

  // ********************************************************************
  // transmit framing parameters, copied so every output is a flop
  // ********************************************************************
  always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      TX_PKT_LEN_O <= `RPQ_RST_PKTLEN;
      // the ninth length bit resets to zero with header control two
      TX_PREAMBLE_LEN_O <= {1'b0, `RPQ_RST_PRELEN};
      TX_SYNC_WORD_O <= `RPQ_RST_SYNC;
      TX_SYNC_LEN_O <= 2'b01;
    end else if (CLK_EN_I) begin
      TX_PKT_LEN_O <= pkt_len;
      TX_PREAMBLE_LEN_O <= {hdr_ctl2[0], pre_len};
      TX_SYNC_WORD_O <= sync_word;
      TX_SYNC_LEN_O <= sync_len;
    end
  end

endmodule // rpq_top

/* tb/rpq_top_assertions.sv */
// port-level checker for the packet qualifier, bound to its top module
`timescale 1ns/1ps
module rpq_checker (
  // clock and reset
  input wire CORE_CLK_I,
  input wire RSTN_I,
  // watched ports
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire [9:0] PADDR_I,
  input wire RX_ENABLE_I,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire PREAMBLE_DET_O,
  input wire INVALID_PREAMBLE_O,
  input wire SYNC_FOUND_O,
  input wire HEADER_OK_O,
  input wire HEADER_FAIL_O,
  input wire TX_START_O,
  input wire TX_ACTIVE_O
);
  // ****************************
  // checks on one clock domain
  // ****************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_rdy1; PREADY_O |=> !PREADY_O; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready long");
  property p_err; PREADY_O && PADDR_I[9:2] == 8'h7f |-> PSLVERR_O; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  // receiver off must drop both preamble levels at once
  property p_rxoff;
    !RX_ENABLE_I |=> !PREAMBLE_DET_O && !INVALID_PREAMBLE_O;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx off kept");
  property p_excl; !(PREAMBLE_DET_O && INVALID_PREAMBLE_O); endproperty
  a_excl: assert property (p_excl) else $error("det and invalid");
  property p_hdr;
    HEADER_OK_O || HEADER_FAIL_O |-> !(HEADER_OK_O && HEADER_FAIL_O)
      ##1 !HEADER_OK_O && !HEADER_FAIL_O;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header verdict");
  property p_sync; $rose(SYNC_FOUND_O) |-> PREAMBLE_DET_O ##1 !SYNC_FOUND_O;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse");
  property p_start;
    TX_START_O |-> TX_ACTIVE_O ##1 (!TX_START_O && TX_ACTIVE_O);
  endproperty
  a_start: assert property (p_start) else $error("tx start");
endmodule // rpq_checker
bind rpq_top rpq_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
  .RX_ENABLE_I(RX_ENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PREAMBLE_DET_O(PREAMBLE_DET_O), .INVALID_PREAMBLE_O(INVALID_PREAMBLE_O),
  .SYNC_FOUND_O(SYNC_FOUND_O), .HEADER_OK_O(HEADER_OK_O),
  .HEADER_FAIL_O(HEADER_FAIL_O), .TX_START_O(TX_START_O),
  .TX_ACTIVE_O(TX_ACTIVE_O));

/* tb/rpq_radio_model.sv */
// remote radio model that sends demodulated bits msb first
`timescale 1ns/1ps
module rpq_radio_model (
  // clock
  input wire clk_i,
  // bit stream
  output reg bit_o,
  output reg valid_o
);
  initial begin
    bit_o = 1'b0;
    valid_o = 1'b0;
  end
  // ****************************
  // frame sender
  // ****************************
  // each bit is followed by gap plus one idle cycles; the idle line shows the inverse bit so a
  // stale value can never pass for real data
  task send(input logic [63:0] pat, input int n, input int gap);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      bit_o <= pat[i];
      valid_o <= 1'b1;
      @(posedge clk_i);
      valid_o <= 1'b0;
      bit_o <= ~pat[i];
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule // rpq_radio_model

/* tb/test_rx_packet_qualifier_autotx.sv */
// self-checking testbench of the packet qualifier and transmit control
`timescale 1ns/1ps
`include "rpq_regs.vh"
module test_rx_packet_qualifier_autotx;
  reg clk, rstn, psel, pen, pwr, rx_en, fwr, fits, sent, aemp;
  reg [9:0] paddr;
  reg [31:0] pwdata, rdat;
  reg [6:0] lvl;
  reg rerr;
  wire [31:0] prdata, rx_hdr_o;
  wire pready, det, inv, gpio, sfound, hok, hfail, start, retx, act, rbit, rvld;
  wire [7:0] plen;
  wire [8:0] prelen;
  wire [1:0] slen;
  wire rerr_w;
  wire [31:0] sword;
  int n_errors = 0, cmp_count = 0, n_ok = 0, n_fail = 0, n_start = 0;
  int n_sync = 0;
  rpq_radio_model u_radio (.clk_i(clk), .bit_o(rbit), .valid_o(rvld));
  rpq_top u_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .CLK_EN_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(rerr_w), .RX_ENABLE_I(rx_en), .RX_BIT_I(rbit),
    .RX_BIT_VALID_I(rvld), .TX_FIFO_LEVEL_I(lvl), .TX_FIFO_WRITE_I(fwr),
    .TX_PKT_FITS_I(fits), .TX_PKT_SENT_I(sent), .TX_ALMOST_EMPTY_I(aemp),
    .PREAMBLE_DET_O(det), .INVALID_PREAMBLE_O(inv), .GPIO_O(gpio),
    .SYNC_FOUND_O(sfound), .HEADER_OK_O(hok), .HEADER_FAIL_O(hfail),
    .RX_HEADER_O(rx_hdr_o), .TX_START_O(start), .TX_RETX_O(retx),
    .TX_ACTIVE_O(act), .TX_PKT_LEN_O(plen), .TX_PREAMBLE_LEN_O(prelen),
    .TX_SYNC_WORD_O(sword), .TX_SYNC_LEN_O(slen));
  // pulse counters so no one-cycle verdict is missed
  always @(posedge clk) begin
    n_ok += hok;
    n_fail += hfail;
    n_start += start;
    n_sync += sfound;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************
  // shared tasks
  // ****************************
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && k++ < 20);
    if (k >= 20) n_errors++;
    rdat = prdata;
    rerr = rerr_w;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task rx_reset;
    rx_en <= 1'b0;
    @(posedge clk);
    rx_en <= 1'b1;
    @(posedge clk);
  endtask
  // ****************************
  // scenarios
  // ****************************
  localparam logic [7:0] RIX [6] = '{8'h34, 8'h35, 8'h36, 8'h43, 8'h33, 8'h60};
  localparam logic [31:0] REV [6] = '{32'h08, 32'h2a, 32'h2dd40000,
    32'hffffffff, 32'h22, 32'h0};
  task t_regs;
    foreach (RIX[i]) begin
      apb(1'b0, RIX[i], 32'h0);
      chk("reset_val", rdat, REV[i]);
    end
    apb(1'b0, 8'h7f, 32'h0);
    chk("slverr", rerr, 32'h1);
    chk("sync_word", sword, 32'h2dd40000);
    apb(1'b1, `RPQ_IDX_HDRCTL2, 32'h23);
    apb(1'b1, `RPQ_IDX_PRELEN, 32'hff);
    settle;
    chk("prelen", prelen, 32'h1ff);
  endtask
  // every sync length code: detect, then time out after sync bits plus four
  task t_pre;
    // short threshold, false detects are tolerable here
    apb(1'b1, `RPQ_IDX_PRECTL, 32'h10);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `RPQ_IDX_HDRCTL2, 32'h10 | (c << 1));
      rx_reset;
      u_radio.send(64'h55, 7, c + 1);
      settle;
      chk("det_early", det, 32'h0);
      u_radio.send(64'h0, 1, 1);
      settle;
      chk("det", det, 32'h1);
      chk("gpio", gpio, 32'h1);
      chk("sync_len", slen, c);
      apb(1'b0, `RPQ_IDX_STATUS2, 32'h0);
      chk("st2_det", rdat[0], 32'h1);
      u_radio.send(64'h0, 8 * (c + 1) + 3, 1);
      settle;
      chk("sync_hunt", det, 32'h1);
      u_radio.send(64'h0, 1, 1);
      settle;
      chk("timeout", det, 32'h0);
    end
  endtask
  task rx_hdr(input logic [7:0] c1, input logic [31:0] en,
              input logic [7:0] hb, input logic ok);
    int o, f, y;
    o = n_ok;
    f = n_fail;
    y = n_sync;
    apb(1'b1, `RPQ_IDX_HDRCTL1, {24'h0, c1});
    apb(1'b1, `RPQ_IDX_HDREN, en);
    rx_reset;
    u_radio.send({24'h0, 8'haa, 16'h2dd4, hb, 8'h77}, 40, 1);
    settle;
    chk("hdr_ok", n_ok - o, ok);
    chk("hdr_fail", n_fail - f, !ok);
    chk("sync_found", n_sync - y, 32'h1);
    chk("rx_hdr", rx_hdr_o[31:16], {hb, 8'h77});
  endtask
  task t_hdr;
    apb(1'b1, `RPQ_IDX_HDRCTL2, 32'h22);
    apb(1'b1, `RPQ_IDX_CHKHDR, 32'h5a770000);
    rx_hdr(8'h08, 32'hffffffff, 8'h5a, 1'b1);
    rx_hdr(8'h08, 32'hffffffff, 8'hff, 1'b0);
    rx_hdr(8'h88, 32'hffffffff, 8'hff, 1'b1);
    rx_hdr(8'h08, 32'h0fffffff, 8'h3a, 1'b1);
    rx_hdr(8'h08, 32'h0fffffff, 8'h3b, 1'b0);
    rx_hdr(8'h04, 32'hffffffff, 8'h00, 1'b1);
    rx_hdr(8'h0c, 32'hffffffff, 8'h11, 1'b0);
  endtask
  task t_inv;
    apb(1'b1, `RPQ_IDX_INVPRE, 32'h20);
    rx_reset;
    u_radio.send(64'hff, 7, 1);
    settle;
    chk("inv_early", inv, 32'h0);
    u_radio.send(64'h1, 1, 1);
    settle;
    chk("inv", inv, 32'h1);
    apb(1'b1, `RPQ_IDX_TXCTRL, 32'h3004);
    settle;
    chk("gpio_inv", gpio, 32'h1);
    apb(1'b0, `RPQ_IDX_STATUS2, 32'h0);
    chk("st2_inv", rdat[1], 32'h1);
    apb(1'b1, `RPQ_IDX_INVPRE, 32'h0);
  endtask
  task t_tx;
    int s;
    s = n_start;
    apb(1'b1, `RPQ_IDX_PKTLEN, 32'h20);
    apb(1'b1, `RPQ_IDX_TXCTRL, 32'h3001);
    settle;
    chk("resend", n_start - s + retx, 32'h2);
    chk("pkt_len", plen, 32'h20);
    sent <= 1'b1;
    @(posedge clk);
    sent <= 1'b0;
    apb(1'b0, `RPQ_IDX_STATUS1, 32'h0);
    settle;
    chk("stop", {rdat[0], act}, 32'h2);
    fits <= 1'b0;
    apb(1'b1, `RPQ_IDX_TXCTRL, 32'h3001);
    settle;
    chk("no_fit", n_start - s, 32'h1);
    fwr <= 1'b1;
    @(posedge clk);
    fwr <= 1'b0;
    lvl <= 7'h30;
    apb(1'b1, `RPQ_IDX_TXCTRL, 32'h3002);
    settle;
    chk("at_thr", n_start - s, 32'h1);
    lvl <= 7'h31;
    settle;
    chk("auto", n_start - s, 32'h2);
    chk("auto_retx", retx, 32'h0);
    lvl <= 7'h0;
    aemp <= 1'b1;
    @(posedge clk);
    aemp <= 1'b0;
    apb(1'b0, `RPQ_IDX_STATUS1, 32'h0);
    settle;
    chk("auto_stop", {rdat[1], act}, 32'h2);
  endtask
  initial begin
    {rstn, psel, pen, pwr, rx_en, fwr, sent, aemp} = 8'h00;
    fits = 1'b1;
    paddr = 10'h000;
    pwdata = 32'h0;
    lvl = 7'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_pre;
    t_hdr;
    t_inv;
    t_tx;
    results;
  end
  // watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    #2000000;
    n_errors++;
    results;
  end
endmodule // test_rx_packet_qualifier_autotx
